// *** pkg/cfg_set_pkg.sv ***
// configuration set loader constants and types
// assumes a single 250 MHz core clock and a word-wide storage read port
package cfg_set_pkg;
  localparam int PARAM_COUNT = 16;
  localparam int WORD_W = 32;
  localparam int IDX_W = 4;
  localparam int SLOT_W = 2;
  localparam logic [SLOT_W-1:0] SLOT_DEFAULT = 2'h0;
  localparam logic [SLOT_W-1:0] SLOT_USER1 = 2'h1;
  localparam logic [SLOT_W-1:0] SLOT_USER2 = 2'h2;
  localparam logic [SLOT_W-1:0] SLOT_USER3 = 2'h3;
  localparam logic [SLOT_W-1:0] BOOT_RESET = 2'h0;
  localparam logic RESTORE_GO = 1'h1;
  localparam logic [WORD_W-1:0] ACTIVE_RESET = 32'h0;
  localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_COPY = 2'b10
  } load_state_t;
endpackage

// *** hw/cfg_copy_walker.sv ***
// walks the parameter index during a copy and flags the last word
// assumes the caller pulses start only when it is not busy
`timescale 1ns/1ps
module cfg_copy_walker
  import cfg_set_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  output logic busy,
  output logic [cfg_set_pkg::IDX_W-1:0] idx,
  output logic last
);
  import cfg_set_pkg::*;

  // ==========================================
  // index counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      idx <= '0;
    end else if (start) begin
      busy <= 1'b1;
      idx <= '0;
    end else if (busy) begin
      if (idx == IDX_LAST) begin
        busy <= 1'b0;
      end
      idx <= idx + 4'h1;
    end
  end
  assign last = busy && (idx == IDX_LAST);
endmodule

// *** hw/cfg_set_loader.sv ***
// loads a stored configuration set into the volatile active set
// assumes storage answers a read address with data one cycle later; acquiring is synchronous
`timescale 1ns/1ps
module cfg_set_loader
  import cfg_set_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [cfg_set_pkg::SLOT_W-1:0] set_slot_choice,
  input wire logic set_restore_command,
  input wire logic [cfg_set_pkg::SLOT_W-1:0] boot_set_choice,
  input wire logic acquiring,
  output logic [cfg_set_pkg::SLOT_W-1:0] nv_rd_slot,
  output logic [cfg_set_pkg::IDX_W-1:0] nv_rd_idx,
  output logic nv_rd_en,
  input wire logic [cfg_set_pkg::WORD_W-1:0] nv_rd_data,
  output logic [cfg_set_pkg::WORD_W*cfg_set_pkg::PARAM_COUNT-1:0] active_cfg,
  output logic load_busy,
  output logic load_ignored
);
  import cfg_set_pkg::*;

  load_state_t state;
  logic [SLOT_W-1:0] src_slot;
  logic start;
  logic walk_busy;
  logic walk_last;
  logic [IDX_W-1:0] walk_idx;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic accept;
  logic [WORD_W-1:0] active_mem [PARAM_COUNT];

  // ==========================================
  // request qualification
  function automatic logic is_restore(input logic cmd);
    return cmd == RESTORE_GO;
  endfunction

  assign accept = (state == ST_IDLE) && is_restore(set_restore_command) && !acquiring;
  assign start = accept || (state == ST_BOOT);

  // ==========================================
  // sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_BOOT;
      src_slot <= SLOT_DEFAULT;
    end else begin
      case (state)
        ST_BOOT: begin
          src_slot <= boot_set_choice;
          state <= ST_COPY;
        end
        ST_IDLE: begin
          if (accept) begin
            src_slot <= set_slot_choice;
            state <= ST_COPY;
          end
        end
        ST_COPY: begin
          if (!walk_busy && !wr_en) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  cfg_copy_walker u_walker (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(start),
    .busy(walk_busy),
    .idx(walk_idx),
    .last(walk_last)
  );

  // ==========================================
  // storage read port
  assign nv_rd_en = walk_busy;
  assign nv_rd_idx = walk_idx;
  assign nv_rd_slot = (state == ST_BOOT) ? boot_set_choice : src_slot;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_en <= 1'b0;
      wr_idx <= '0;
    end else begin
      wr_en <= walk_busy;
      wr_idx <= walk_idx;
    end
  end

  // ==========================================
  // volatile active set, cleared at reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        active_mem[i] <= ACTIVE_RESET;
      end
    end else if (wr_en) begin
      active_mem[wr_idx] <= nv_rd_data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PARAM_COUNT; g++) begin : g_out
      assign active_cfg[g*WORD_W +: WORD_W] = active_mem[g];
    end
  endgenerate

  // ==========================================
  // status
  assign load_busy = (state != ST_IDLE);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      load_ignored <= 1'b0;
    end else begin
      load_ignored <= is_restore(set_restore_command) && acquiring;
    end
  end

  // ==========================================
  // checks
  a_busy_no_start: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ST_IDLE && set_restore_command && acquiring) |=> state == ST_IDLE)
    else $error("load started during acquisition");

  a_load_starts: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ST_IDLE && set_restore_command && !acquiring) |=> nv_rd_en && nv_rd_idx == 4'h0)
    else $error("load did not start");

  a_slot_held: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ST_IDLE && accept) |=> nv_rd_slot == $past(set_slot_choice))
    else $error("wrong source slot");

  a_copy_length: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(walk_busy) |-> ##15 walk_last ##1 !walk_busy)
    else $error("copy did not cover every parameter");

  a_write_follows: assert property (@(posedge core_clk) disable iff (!nrst)
    nv_rd_en |=> wr_en && wr_idx == $past(nv_rd_idx))
    else $error("stored word not written");

  a_boot_load: assert property (@(posedge core_clk) disable iff (!nrst)
    state == ST_BOOT |=> nv_rd_en && src_slot == $past(boot_set_choice))
    else $error("startup set not loaded");

  a_copy_ends: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(walk_busy) |-> ##[17:19] state == ST_IDLE)
    else $error("copy did not finish");

  a_ignored_flag: assert property (@(posedge core_clk) disable iff (!nrst)
    (set_restore_command && acquiring) |=> load_ignored)
    else $error("ignored load not flagged");

  // ==========================================
  // read strobe tally, one load at a time
  logic [IDX_W:0] rd_count;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_count <= '0;
    end else if (start) begin
      rd_count <= '0;
    end else if (nv_rd_en) begin
      rd_count <= rd_count + 5'h1;
    end
  end

  a_read_count: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(nv_rd_en) |-> rd_count == (IDX_W + 1)'(PARAM_COUNT))
    else $error("wrong number of stored words read");

  a_idx_steps: assert property (@(posedge core_clk) disable iff (!nrst)
    (nv_rd_en && nv_rd_idx != IDX_LAST) |=> nv_rd_en && nv_rd_idx == $past(nv_rd_idx) + 4'h1)
    else $error("read index skipped");

  a_slot_steady: assert property (@(posedge core_clk) disable iff (!nrst)
    (nv_rd_en && $past(nv_rd_en)) |-> $stable(nv_rd_slot))
    else $error("source slot changed during copy");

  a_read_in_load: assert property (@(posedge core_clk) disable iff (!nrst)
    nv_rd_en |-> load_busy)
    else $error("storage read outside a load");

  a_no_read_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    state == ST_IDLE |-> !nv_rd_en && !wr_en)
    else $error("storage access while idle");

  // ==========================================
  // checks on the active set
  a_word_lands: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en |=> active_mem[$past(wr_idx)] == $past(nv_rd_data))
    else $error("stored word not copied");

  a_active_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !wr_en |=> $stable(active_cfg))
    else $error("active set changed without a load");

  a_reset_clears: assert property (@(posedge core_clk)
    !nrst |-> active_cfg == '0)
    else $error("active set kept through reset");

  a_reset_outputs: assert property (@(posedge core_clk)
    !nrst |-> load_busy && !nv_rd_en && !load_ignored)
    else $error("outputs not at reset values");

  // ==========================================
  // checks on requests
  a_start_idle_only: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(nv_rd_en) |-> $past(state) == ST_BOOT || !$past(acquiring))
    else $error("load started while acquiring");

  a_ignored_only: assert property (@(posedge core_clk) disable iff (!nrst)
    load_ignored |-> $past(set_restore_command) && $past(acquiring))
    else $error("ignored flag without a refused request");

  a_boot_once: assert property (@(posedge core_clk) disable iff (!nrst)
    state != ST_BOOT |=> state != ST_BOOT)
    else $error("startup load repeated without reset");
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the configuration set loader
// assumes the loader package and design are compiled first; bench models the storage
`timescale 1ns/1ps
module tb;
  import cfg_set_pkg::*;
  localparam int AW = WORD_W * PARAM_COUNT;
  logic core_clk, nrst, set_restore_command, acquiring, nv_rd_en, load_busy, load_ignored;
  logic [SLOT_W-1:0] set_slot_choice, boot_set_choice, nv_rd_slot;
  logic [IDX_W-1:0] nv_rd_idx;
  logic [WORD_W-1:0] nv_rd_data;
  logic [AW-1:0] active_cfg, held;
  logic [23:0] salt;
  int n_mismatch, samples_checked;
  // ========
  // design and storage model
  cfg_set_loader DUT (.core_clk(core_clk), .nrst(nrst), .set_slot_choice(set_slot_choice),
    .set_restore_command(set_restore_command), .boot_set_choice(boot_set_choice),
    .acquiring(acquiring), .nv_rd_slot(nv_rd_slot), .nv_rd_idx(nv_rd_idx),
    .nv_rd_en(nv_rd_en), .nv_rd_data(nv_rd_data), .active_cfg(active_cfg),
    .load_busy(load_busy), .load_ignored(load_ignored));
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  // storage answers one cycle after the strobe, else shows a changing pattern
  always @(posedge core_clk) begin
    nv_rd_data <= nv_rd_en ? {salt, 2'h0, nv_rd_slot, nv_rd_idx} : ~nv_rd_data;
  end
  // ========
  // expectations and checks
  function automatic logic [AW-1:0] exp_set(input logic [SLOT_W-1:0] s);
    for (int i = 0; i < PARAM_COUNT; i++) exp_set[i*WORD_W +: WORD_W] = {salt, 2'h0, s, 4'(i)};
  endfunction
  task automatic chk(input string what, input logic [AW-1:0] seen, input logic [AW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 40 && load_busy !== 1'h0; n++) @(negedge core_clk);
    chk("load_busy", AW'(load_busy), AW'(0));
  endtask
  // ========
  // scenarios
  task automatic do_reset(input logic [SLOT_W-1:0] b);
    nrst = 1'h0;
    boot_set_choice = b;
    repeat (3) @(negedge core_clk);
    chk("active_cfg in reset", active_cfg, '0);
    nrst = 1'h1;
    @(negedge core_clk);
    wait_idle;
    chk("startup set", active_cfg, exp_set(b));
    boot_set_choice = 2'($urandom);
    $display("test reset with startup slot %0d done", b);
  endtask
  task automatic load(input logic [SLOT_W-1:0] s, input logic acq);
    held = active_cfg;
    set_slot_choice = s;
    acquiring = acq;
    set_restore_command = 1'h1;
    @(negedge core_clk);
    set_restore_command = 1'h0;
    set_slot_choice = 2'($urandom);
    if (acq) begin
      chk("load_ignored", AW'(load_ignored), AW'(1));
      chk("load_busy", AW'(load_busy), AW'(0));
      @(negedge core_clk);
      acquiring = 1'h0;
      chk("active unchanged", active_cfg, held);
    end else begin
      acquiring = 1'h0;
      chk("load_ignored", AW'(load_ignored), AW'(0));
      wait_idle;
      chk("loaded set", active_cfg, exp_set(s));
    end
    $display("test load slot %0d acquiring %0b done", s, acq);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end
  initial begin
    void'($urandom(32'hBFE1));
    {nrst, set_restore_command, acquiring, set_slot_choice, boot_set_choice} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    salt = 24'($urandom);
    nv_rd_data = 32'h0;
    do_reset(SLOT_USER3);
    for (int k = 0; k < 4; k++) load(2'(k), 1'h0);
    for (int k = 0; k < 8; k++) load(2'($urandom), 1'($urandom));
    do_reset(SLOT_DEFAULT);
    load(SLOT_USER1, 1'h1);
    do_reset(2'($urandom));
    final_report;
  end
endmodule
